// ### pls_params.svh
// Register offsets, field positions and reset values of the logic slice group.
`ifndef PLS_PARAMS_SVH
`define PLS_PARAMS_SVH
`define PLS_LUT_BASE       8'h00
`define PLS_CFG_BASE       8'h10
`define PLS_GRP_OFS        8'h20
`define PLS_STAT_OFS       8'h24
`define PLS_CFG_MODE_LSB   0
`define PLS_CFG_OP_LSB     2
`define PLS_CFG_FAST_BIT   5
`define PLS_CFG_NEG_BIT    6
`define PLS_CFG_LEVEL_BIT  7
`define PLS_CFG_ASYNC_BIT  8
`define PLS_CFG_SETV_BIT   9
`define PLS_CFG_CLKSEL_BIT 10
`define PLS_CFG_BITS       11
`define PLS_GRP_DUAL_BIT   0
`define PLS_STAT_CAP_BIT   8
`define PLS_LUT_BITS       16
`define PLS_LUT_RST        16'h0000
`define PLS_CFG_RST        11'h000
`define PLS_GRP_RST        1'b0
`endif

// ### pls_pkg.sv
// Types shared by the logic slice group.
package pls_pkg;
  typedef enum logic [1:0]
  {
    PLS_LOGIC  = 2'b00,
    PLS_RIPPLE = 2'b01,
    PLS_RAM    = 2'b10,
    PLS_ROM    = 2'b11
  } pls_mode_t;
  typedef enum logic [2:0]
  {
    PLS_ADD    = 3'b000,
    PLS_SUB    = 3'b001,
    PLS_ADDSUB = 3'b010,
    PLS_UPCNT  = 3'b011,
    PLS_DNCNT  = 3'b100,
    PLS_UDCNT  = 3'b101,
    PLS_CMP    = 3'b110,
    PLS_MULT   = 3'b111
  } pls_op_t;
  // Slice 0..2 routing inputs; in0/in1 are {d,c,b,a} of each table.
  typedef struct packed {
    logic       rclk;
    logic       ce;
    logic       sr;
    logic       m1;
    logic       m0;
    logic [3:0] in1;
    logic [3:0] in0;
  } pls_slice_in_t;
  typedef struct packed {
    logic       m1;
    logic       m0;
    logic [3:0] in1;
    logic [3:0] in0;
  } pls_s3_in_t;
  typedef struct packed {
    logic ofx1;
    logic ofx0;
    logic q1;
    logic q0;
    logic f1;
    logic f0;
  } pls_slice_out_t;
  typedef struct packed {
    logic ofx1;
    logic ofx0;
    logic f1;
    logic f0;
  } pls_s3_out_t;
  typedef struct packed {
    logic      clksel;
    logic      setv;
    logic      async_sr;
    logic      level;
    logic      neg;
    logic      fast;
    pls_op_t   op;
    pls_mode_t mode;
  } pls_cfg_t;
endpackage

// ### pls_group.sv
// Four-slice programmable logic group with an AHB-Lite configuration port.
//
// Notes on behaviour
// - Slices 0..2 have two tables and two registers; slice 3 tables only.
// - Slice registers choose clock polarity and edge or level sensitivity.
// - Set/reset selectable sync or async; clock select, chip-select, wide memory control.
// - Logic mode: each table returns any function of its 16 input codes.
// - Two tables form a five-input function; wider ones chain further slices.
// - Ripple: 2-bit add, subtract, or add/subtract chosen by a live input.
// - Ripple: 2-bit up, down, up/down counters with async clear, sync preload.
// - Ripple: compare A,B for >=, !=, <=; also multiplier building block.
// - Fast carry option outputs carry generate and propagate per slice.
// - Slices 0..2: 13 inputs, carry in, 6 outputs, carry out; slice 3: 10/4.
// - RAM mode: 16x4 single port in slices 0,1; slice 2 gives address, control.
// - 16x2 pseudo dual port: one slice read-write, its companion read-only.
// - Both memory forms, 16x4 single port and 16x2 pseudo dual port, occupy three slices.
// - Only slices 0,1 of a RAM-capable group act as memory.
// - Modes are logic, ripple, RAM, ROM; slice 3 only logic or ROM.
// - Table contents load with initial values at reset and by software.
`timescale 1ns/100ps
`default_nettype none
`include "pls_params.svh"
module pls_group
  import pls_pkg::*;
#(
  parameter int unsigned RAM_CAPABLE = 1,
  parameter logic [127:0] LUT_INIT   = {8{`PLS_LUT_RST}}
)(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire pls_slice_in_t [2:0]  sin,
  input  wire pls_s3_in_t           s3in,
  input  wire logic                 fci,
  input  wire logic                 fxin,
  output pls_slice_out_t [2:0]      sout,
  output pls_s3_out_t               s3out,
  output logic                      fco
);
  if (RAM_CAPABLE > 1)
  begin : g_bad_param
    $error("RAM_CAPABLE must be 0 or 1");
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Decode returns {hit, word index}; offsets are contiguous words.
  function automatic logic [4:0] pls_decode(input logic [31:0] a);
    logic ok;
    ok = (a[31:8] == 24'h000000) && (a[1:0] == 2'b00) && (a[7:0] <= `PLS_STAT_OFS);
    return {ok, a[5:2]};
  endfunction

  function automatic logic mode_allowed(input int s, input pls_mode_t m);
    if (s == 3)
      return (m == PLS_LOGIC) || (m == PLS_ROM);
    if (m == PLS_RAM)
      return RAM_CAPABLE == 1;
    return 1'b1;
  endfunction

  logic [15:0] lut_reg [8];
  pls_cfg_t    cfg_reg [4];
  logic        dual_reg;
  logic        wr_pend_reg;
  logic [4:0]  wr_dec_reg;
  logic [31:0] hrdata_reg;
  logic [4:0]  ad_dec;
  logic        accept;
  logic        wr_hit;
  logic        lut_wr_hit;
  logic [5:0]  q_all;
  logic [3:0]  cy;

  assign accept     = hsel & htrans[1] & hready;
  assign ad_dec     = pls_decode(haddr);
  assign wr_hit     = wr_pend_reg & wr_dec_reg[4];
  assign lut_wr_hit = wr_hit & (wr_dec_reg[3:0] < 4'(`PLS_CFG_BASE >> 2));
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_reg;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      wr_dec_reg  <= 5'h00;
    end
    else
    begin
      wr_pend_reg <= accept & hwrite;
      wr_dec_reg  <= ad_dec;
    end
  end

  // Read data is captured in the address phase so it stands for the data phase.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata_reg <= 32'h00000000;
    else if (accept && !hwrite)
    begin
      hrdata_reg <= 32'h00000000;
      if (ad_dec[4])
      begin
        if (ad_dec[3:0] < 4'(`PLS_CFG_BASE >> 2))
          hrdata_reg <= {lut_reg[{ad_dec[1:0], 1'b1}], lut_reg[{ad_dec[1:0], 1'b0}]};
        else if (ad_dec[3:0] < 4'(`PLS_GRP_OFS >> 2))
          hrdata_reg <= {21'h000000, cfg_reg[ad_dec[1:0]]};
        else if (ad_dec[3:0] == 4'(`PLS_GRP_OFS >> 2))
          hrdata_reg[`PLS_GRP_DUAL_BIT] <= dual_reg;
        else
        begin
          hrdata_reg[5:0]               <= q_all;
          hrdata_reg[`PLS_STAT_CAP_BIT] <= (RAM_CAPABLE == 1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  // A mode that the slice cannot serve is refused; the old mode stays.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
        cfg_reg[i] <= `PLS_CFG_RST;
    end
    else if (wr_hit && wr_dec_reg[3:2] == 2'b01)
    begin
      cfg_reg[wr_dec_reg[1:0]] <= hwdata[`PLS_CFG_BITS-1:0];
      if (!mode_allowed(int'(wr_dec_reg[1:0]), pls_mode_t'(hwdata[1:0])))
        cfg_reg[wr_dec_reg[1:0]].mode <= cfg_reg[wr_dec_reg[1:0]].mode;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      dual_reg <= `PLS_GRP_RST;
    else if (wr_hit && wr_dec_reg[3:0] == 4'(`PLS_GRP_OFS >> 2))
      dual_reg <= hwdata[`PLS_GRP_DUAL_BIT];
  end

  // ----------------------------------------------------------------
  // Distributed memory
  // ----------------------------------------------------------------
  logic       ram_wr;
  logic [3:0] wa;
  logic [3:0] ram_din;
  logic [3:0] ram_we;

  // Slice 2 lends its write address, write enable and chip-select.
  assign ram_wr  = (RAM_CAPABLE == 1) && (cfg_reg[2].mode == PLS_RAM) && sin[2].ce && sin[2].m0;
  assign wa      = sin[2].in0;
  // In dual-port form slice 1 mirrors slice 0 and is read from its own address.
  assign ram_din = dual_reg ? {sin[0].m1, sin[0].m0, sin[0].m1, sin[0].m0}
                            : {sin[1].m1, sin[1].m0, sin[0].m1, sin[0].m0};

  for (genvar j = 0; j < 4; j++)
  begin : g_we
    assign ram_we[j] = ram_wr && (cfg_reg[j/2].mode == PLS_RAM);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int j = 0; j < 8; j++)
        lut_reg[j] <= LUT_INIT[j*16 +: 16];
    end
    else
    begin
      for (int j = 0; j < 4; j++)
        if (ram_we[j])
          lut_reg[j][wa] <= ram_din[j];
      if (lut_wr_hit)
      begin
        lut_reg[{wr_dec_reg[1:0], 1'b0}] <= hwdata[15:0];
        lut_reg[{wr_dec_reg[1:0], 1'b1}] <= hwdata[31:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Wide function muxes
  // ----------------------------------------------------------------
  logic [3:0] five_input_lookup_function_w;
  logic [1:0] lut6_w;
  logic       lut7_w;
  logic       s3f0;
  logic       s3f1;

  assign s3f0      = lut_reg[6][s3in.in0];
  assign s3f1      = lut_reg[7][s3in.in1];
  assign five_input_lookup_function_w[3] = s3in.m0 ? s3f1 : s3f0;
  assign lut6_w[0] = sin[0].m1 ? five_input_lookup_function_w[1] : five_input_lookup_function_w[0];
  assign lut6_w[1] = sin[2].m1 ? five_input_lookup_function_w[3] : five_input_lookup_function_w[2];
  assign lut7_w    = sin[1].m1 ? lut6_w[1] : lut6_w[0];
  // Eight inputs need a neighbouring group, which arrives on fxin.
  assign s3out     = {s3in.m1 ? fxin : lut7_w, five_input_lookup_function_w[3], s3f1, s3f0};
  assign cy[0]     = fci;
  assign fco       = cy[3];

  // ----------------------------------------------------------------
  // Slices with registers
  // ----------------------------------------------------------------
  for (genvar s = 0; s < 3; s++)
  begin : g_slice
    pls_cfg_t   c;
    logic [1:0] x, y, yy, q_reg, q_out, ff, q_d;
    logic [2:0] sum, gsum;
    logic       f0, f1, g, p, ne, ofx0, ofx1, ci, ripple, cnt;
    logic       rclk, clk_prev_reg, ev_clk, ev, async_on;

    assign c      = cfg_reg[s];
    assign ci     = cy[s];
    assign ripple = (c.mode == PLS_RIPPLE);
    assign cnt    = (c.op == PLS_UPCNT) || (c.op == PLS_DNCNT) || (c.op == PLS_UDCNT);
    assign f0     = lut_reg[2*s][sin[s].in0];
    assign f1     = lut_reg[2*s+1][sin[s].in1];
    assign five_input_lookup_function_w[s] = sin[s].m0 ? f1 : f0;

    // A operand is {a1,a0}, B is {b1,b0}; c0 steers direction or subtract.
    always_comb
    begin
      x  = {sin[s].in1[0], sin[s].in0[0]};
      y  = {sin[s].in1[1], sin[s].in0[1]};
      yy = y;
      case (c.op)
        PLS_SUB:    yy = ~y;
        PLS_ADDSUB: yy = sin[s].in0[2] ? ~y : y;
        PLS_UPCNT:  begin x = q_reg; yy = 2'b00; end
        PLS_DNCNT:  begin x = q_reg; yy = 2'b11; end
        PLS_UDCNT:  begin x = q_reg; yy = {2{sin[s].in0[2]}}; end
        PLS_MULT:   x = x & {2{sin[s].m0}};
        default:    yy = y;
      endcase
      gsum = {1'b0, x} + {1'b0, yy};
      sum  = gsum + {2'b00, ci};
    end

    assign g  = gsum[2];
    assign p  = &(x ^ yy);
    assign ne = (x != y) | ci;
    // Lookahead and ripple carries agree; the fast form only shortens the path.
    assign cy[s+1] = !ripple ? 1'b0 : (c.op == PLS_CMP) ? ne
                   : c.fast ? (g | (p & ci)) : sum[2];
    assign ff   = !ripple ? {f1, f0}
                : (c.op == PLS_CMP) ? {x <= y, x >= y} : sum[1:0];
    assign ofx0 = !ripple ? five_input_lookup_function_w[s] : (c.op == PLS_CMP) ? ne : (c.fast & g);
    assign ofx1 = !ripple ? ((s == 1) ? lut7_w : lut6_w[s/2]) : (c.fast & p);

    // Fabric clock is sampled, so its edges and levels are seen one clock late.
    assign rclk   = c.clksel ? sin[0].rclk : sin[s].rclk;
    assign ev_clk = c.level ? (rclk ^ c.neg)
                  : c.neg ? (clk_prev_reg & ~rclk) : (~clk_prev_reg & rclk);
    assign ev       = ev_clk & sin[s].ce;
    assign async_on = sin[s].sr & c.async_sr;
    assign q_d      = (ripple && cnt && sin[s].in1[2]) ? {sin[s].m1, sin[s].m0} : ff;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
        clk_prev_reg <= 1'b0;
      else
        clk_prev_reg <= rclk;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
        q_reg <= 2'b00;
      else if (async_on)
        q_reg <= {2{c.setv}};
      else if (sin[s].sr && ev_clk)
        q_reg <= {2{c.setv}};
      else if (ev)
        q_reg <= q_d;
    end

    // The asynchronous form also overrides the output at once.
    assign q_out   = async_on ? {2{c.setv}} : q_reg;
    assign sout[s] = {ofx1, ofx0, q_out, ff};
    assign q_all[2*s +: 2] = q_out;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s0_rise_s;
    !sin[0].rclk ##1 sin[0].rclk;
  endsequence
  sequence s0_edge_ok_s;
    sin[0].ce && !sin[0].sr && !cfg_reg[0].level && !cfg_reg[0].neg && !cfg_reg[0].clksel;
  endsequence

  edge_capture_a: assert property (
    (s0_rise_s ##0 s0_edge_ok_s) |=> g_slice[0].q_reg == $past(g_slice[0].q_d))
    else $error("slice 0 register missed a rising edge");
  slice3_mode_a: assert property (
    cfg_reg[3].mode == PLS_LOGIC || cfg_reg[3].mode == PLS_ROM)
    else $error("slice 3 entered a forbidden mode");
  rom_hold_a: assert property (
    (cfg_reg[0].mode == PLS_ROM && !lut_wr_hit) |=> $stable(lut_reg[0]))
    else $error("ROM contents changed");
  ram_write_a: assert property (
    (ram_we[0] && !lut_wr_hit) |=> lut_reg[0][$past(wa)] == $past(ram_din[0]))
    else $error("RAM write not stored");
  dual_mirror_a: assert property (
    (ram_we[2] && dual_reg && !lut_wr_hit) |=> lut_reg[2][$past(wa)] == $past(sin[0].m0))
    else $error("read-only port not updated");
  async_clear_a: assert property (
    (sin[0].sr && cfg_reg[0].async_sr)
      |-> sout[0].q0 == cfg_reg[0].setv ##1 g_slice[0].q_reg == {2{$past(cfg_reg[0].setv)}})
    else $error("asynchronous set or reset ignored");
  add_result_a: assert property (
    (cfg_reg[0].mode == PLS_RIPPLE && cfg_reg[0].op == PLS_ADD && !cfg_reg[0].fast)
      |-> {cy[1], sout[0].f1, sout[0].f0} == {1'b0, g_slice[0].x} + {1'b0, g_slice[0].y} + {2'b00, fci})
    else $error("2-bit add wrong");
  fast_carry_a: assert property (
    (cfg_reg[1].mode == PLS_RIPPLE && cfg_reg[1].fast && cfg_reg[1].op != PLS_CMP)
      |-> cy[2] == g_slice[1].sum[2] && sout[1].ofx1 == g_slice[1].p)
    else $error("fast carry disagrees with ripple sum");
  compare_a: assert property (
    (cfg_reg[0].mode == PLS_RIPPLE && cfg_reg[0].op == PLS_CMP)
      |-> sout[0].f0 == (g_slice[0].x >= g_slice[0].y) && sout[0].f1 == (g_slice[0].x <= g_slice[0].y))
    else $error("comparator output wrong");
  five_input_lookup_function_sel_a: assert property (
    cfg_reg[0].mode == PLS_LOGIC |-> sout[0].ofx0 == (sin[0].m0 ? sout[0].f1 : sout[0].f0))
    else $error("five-input select wrong");
endmodule // pls_group
`default_nettype wire

// ### pls_fabric_model.sv
// Routing fabric and carry-chain partner that drives the slice inputs of the group.
`timescale 1ns/100ps
`default_nettype none
module pls_fabric_model
  import pls_pkg::*;
(
  input  wire logic           core_clk,
  output pls_slice_in_t [2:0] sin,
  output pls_s3_in_t          s3in,
  output logic                fci,
  output logic                fxin
);
  initial
  begin
    sin  = '0;
    s3in = '0;
    fci  = 1'b0;
    fxin = 1'b0;
  end
  // Callers enter right after a rising edge; the fabric only ever drives on that edge.
  // Thirteen routing lines per register slice plus carry in.
  task automatic put(input int s, input pls_slice_in_t v);
    sin[s] <= v;
  endtask
  // Ten routing lines into the table-only slice, plus the wide-function feed.
  task automatic put3(input pls_s3_in_t v, input logic fx);
    s3in <= v;
    fxin <= fx;
  endtask
  task automatic carry(input logic c);
    fci <= c;
  endtask
endmodule // pls_fabric_model
`default_nettype wire

// ### pls_group_bench.sv
// Self-checking bench for the four-slice logic group and its configuration port.
`timescale 1ns/100ps
`default_nettype none
module pls_group_bench
  import pls_pkg::*;
;
  typedef struct packed
  {
    logic [10:0] cfg;
    logic [3:0]  in1;
    logic [3:0]  in0;
    logic        m0;
    logic        cin;
    logic [2:0]  mask;
    logic [2:0]  exp;
  } pls_row_t;
  // Rows drive slice 0 with table 0 = xor4 and table 1 = and4; result is {ofx0, f1, f0}.
  localparam pls_row_t ROWS [10] = '{
    '{11'h000, 4'hf, 4'h7, 1'b0, 1'b0, 3'h7, 3'h7},
    '{11'h000, 4'hf, 4'h3, 1'b1, 1'b0, 3'h7, 3'h6},
    '{11'h000, 4'he, 4'h3, 1'b1, 1'b0, 3'h7, 3'h0},
    '{11'h003, 4'hf, 4'h1, 1'b0, 1'b0, 3'h3, 3'h3},
    '{11'h001, 4'h1, 4'h3, 1'b0, 1'b0, 3'h3, 3'h0},
    '{11'h005, 4'h2, 4'h1, 1'b0, 1'b1, 3'h3, 3'h3},
    '{11'h009, 4'h1, 4'h7, 1'b0, 1'b1, 3'h3, 3'h2},
    '{11'h009, 4'h1, 4'h3, 1'b0, 1'b1, 3'h3, 3'h1},
    '{11'h019, 4'h3, 4'h0, 1'b0, 1'b0, 3'h7, 3'h3},
    '{11'h019, 4'h2, 4'h1, 1'b0, 1'b0, 3'h7, 3'h6}};
  logic                core_clk;
  logic                rst_n;
  logic                hsel;
  logic                hwrite;
  logic                hreadyout;
  logic                hresp;
  logic                fci;
  logic                fxin;
  logic                fco;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [31:0]         haddr;
  logic [31:0]         hwdata;
  logic [31:0]         hrdata;
  logic [31:0]         rd;
  pls_slice_in_t [2:0] sin;
  pls_s3_in_t          s3in;
  pls_s3_in_t          t3;
  pls_slice_out_t[2:0] sout;
  pls_s3_out_t         s3out;
  pls_slice_in_t       s0;
  pls_slice_in_t       w;
  int                  fails;
  int                  samples_checked;
  int                  cycles;

  pls_fabric_model fab (.core_clk(core_clk), .sin(sin), .s3in(s3in), .fci(fci), .fxin(fxin));
  pls_group #(.RAM_CAPABLE(1), .LUT_INIT(128'ha5c3)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sin(sin), .s3in(s3in),
    .fci(fci), .fxin(fxin), .sout(sout), .s3out(s3out), .fco(fco));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Every driver starts on a rising edge so inputs never move on a sampling edge.
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask
  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic apply(input int s, input pls_slice_in_t v);
    @(posedge core_clk);
    fab.put(s, v);
    @(negedge core_clk);
  endtask
  // The fabric clock is slow: each phase is held for at least hold+1 core cycles.
  task automatic tick(input int hold);
    s0.rclk = ~s0.rclk;
    apply(0, s0);
    repeat (hold) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      results();
    end
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    s0 = '0;
    w = '0;
    t3 = '0;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    apply(0, s0);
    chk("hrdata after reset", 32'h0, hrdata);
    chk("initial table output", 32'h1, {31'h0, sout[0].f0});
    rdchk("table 0 reset", 32'h00, 32'h0000_a5c3);
    rdchk("config 0 reset", 32'h10, 32'h0);
    rdchk("status reset", 32'h24, 32'h100);
    chk("response", 32'h0, {31'h0, hresp});
    ahb(1'b1, 32'h28, 32'hffff_ffff);
    rdchk("unmapped", 32'h28, 32'h0);
    for (int m = 1; m < 3; m++)
    begin
      ahb(1'b1, 32'h1c, 32'h18 | m);
      rdchk("slice 3 mode", 32'h1c, 32'h18);
    end
    $display("test reset and bus done");
    ahb(1'b1, 32'h00, 32'h8000_6996);
    foreach (ROWS[i])
    begin
      ahb(1'b1, 32'h10, {21'h0, ROWS[i].cfg});
      fab.carry(ROWS[i].cin);
      s0 = '0;
      s0.in0 = ROWS[i].in0;
      s0.in1 = ROWS[i].in1;
      s0.m0 = ROWS[i].m0;
      apply(0, s0);
      chk($sformatf("row %0d", i), {29'h0, ROWS[i].exp},
          {29'h0, {sout[0].ofx0, sout[0].f1, sout[0].f0} & ROWS[i].mask});
    end
    $display("test table rows done");
    ahb(1'b1, 32'h10, 32'h0);
    s0.ce = 1'b1;
    s0.in0 = 4'h7;
    apply(0, s0);
    repeat (3) @(posedge core_clk);
    chk("no clock no load", 32'h0, {31'h0, sout[0].q0});
    tick(3);
    chk("rising load", 32'h1, {31'h0, sout[0].q0});
    ahb(1'b1, 32'h10, 32'h40);
    s0.in0 = 4'h0;
    tick(3);
    chk("falling load", 32'h0, {31'h0, sout[0].q0});
    ahb(1'b1, 32'h10, 32'h200);
    s0.ce = 1'b0;
    s0.sr = 1'b1;
    apply(0, s0);
    repeat (3) @(posedge core_clk);
    chk("sync set waits", 32'h0, {31'h0, sout[0].q0});
    tick(3);
    chk("sync set", 32'h1, {31'h0, sout[0].q0});
    ahb(1'b1, 32'h10, 32'h100);
    @(negedge core_clk);
    chk("async reset", 32'h0, {31'h0, sout[0].q0});
    ahb(1'b1, 32'h10, 32'h00d);
    fab.carry(1'b1);
    s0 = '{rclk: 1'b1, ce: 1'b1, m1: 1'b1, in1: 4'h4, default: '0};
    tick(3);
    tick(3);
    chk("preload", 32'h2, {30'h0, sout[0].q1, sout[0].q0});
    s0.in1 = 4'h0;
    tick(3);
    tick(3);
    chk("count up", 32'h3, {30'h0, sout[0].q1, sout[0].q0});
    rdchk("status q", 32'h24, 32'h103);
    ahb(1'b1, 32'h10, 32'h80);
    s0.in0 = 4'h1;
    apply(0, s0);
    @(negedge core_clk);
    chk("level load", 32'h1, {31'h0, sout[0].q0});
    s0.rclk = 1'b0;
    s0.in0 = 4'h0;
    apply(0, s0);
    repeat (2) @(negedge core_clk);
    chk("level closed", 32'h1, {31'h0, sout[0].q0});
    $display("test registers done");
    for (int s = 0; s < 3; s++) ahb(1'b1, 32'h10 + 4 * s, 32'h2);
    s0 = '0;
    s0.m0 = 1'b1;
    s0.in0 = 4'h5;
    apply(0, s0);
    w = '{ce: 1'b1, m0: 1'b1, in0: 4'h5, default: '0};
    apply(2, w);
    @(negedge core_clk);
    chk("ram write read", 32'h1, {31'h0, sout[0].f0});
    apply(2, '0);
    rdchk("ram contents", 32'h00, 32'h8000_69b6);
    ahb(1'b1, 32'h10, 32'h3);
    s0.m0 = 1'b0;
    apply(0, s0);
    apply(2, w);
    @(negedge core_clk);
    chk("rom ignores write", 32'h1, {31'h0, sout[0].f0});
    apply(2, '0);
    ahb(1'b1, 32'h20, 32'h1);
    rdchk("dual form", 32'h20, 32'h1);
    s0.m0 = 1'b1;
    apply(0, s0);
    apply(1, '{in0: 4'h5, default: '0});
    apply(2, w);
    @(negedge core_clk);
    chk("read-only port", 32'h1, {31'h0, sout[1].f0});
    apply(2, '0);
    $display("test memory done");
    for (int s = 0; s < 3; s++) ahb(1'b1, 32'h10 + 4 * s, 32'h1);
    ahb(1'b1, 32'h14, 32'h21);
    w = '{in0: 4'h3, in1: 4'h3, default: '0};
    fab.carry(1'b0);
    fab.put(0, w);
    fab.put(1, w);
    apply(2, w);
    chk("carry chain", 32'h1de,
        {23'h0, fco, sout[2][1:0], sout[1][5:4], sout[1][1:0], sout[0][1:0]});
    ahb(1'b1, 32'h18, 32'h0);
    @(negedge core_clk);
    chk("carry off", 32'h0, {31'h0, fco});
    ahb(1'b1, 32'h0c, 32'h2);
    t3.m1 = 1'b1;
    t3.in0 = 4'h1;
    @(posedge core_clk);
    fab.put3(t3, 1'b1);
    @(negedge core_clk);
    chk("slice 3", 32'hd, {28'h0, s3out});
    $display("test carry and slice 3 done");
    results();
  end
endmodule // pls_group_bench
`default_nettype wire
